//--- mrw_pin_model.sv
// partner: board reset source with a pull-up on the reset pin
`timescale 1ns/1ns
module mrw_pin_model (
    input wire logic aclk,
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic hold_low,
    output logic pin_level
);
    logic stretch_q;
    // ------------------------------------------------------------
    // pulse shaping
    // ------------------------------------------------------------
    // a request is stretched one cycle, so no pulse is too short
    always_ff @(posedge aclk) begin
        stretch_q <= hold_low;
    end
    // wired level: anyone pulling low wins, released line floats high
    assign pin_level = (pin_oe && !pin_o) || hold_low || stretch_q ?
        1'b0 : 1'b1;
endmodule

//--- mrw_pkg.sv
// package: constants and types for the reset and watchdog service block
package mrw_pkg;
    // ------------------------------------------------------------
    // register map (printed offsets are word indices; byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] WDG_KEY_IDX = 8'h1D;
    localparam logic [7:0] WDG_CTRL_IDX = 8'h1E;
    localparam logic [7:0] RST_STATE_IDX = 8'h20;
    localparam logic [7:0] SERIAL_IDX = 8'h21;
    localparam logic [9:0] WDG_KEY_ADDR = {WDG_KEY_IDX, 2'b00};
    localparam logic [9:0] WDG_CTRL_ADDR = {WDG_CTRL_IDX, 2'b00};
    localparam logic [9:0] RST_STATE_ADDR = {RST_STATE_IDX, 2'b00};
    localparam logic [9:0] SERIAL_ADDR = {SERIAL_IDX, 2'b00};
    // ------------------------------------------------------------
    // key values and reset loads
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_ARM = 8'h55;
    localparam logic [7:0] KEY_FIRE = 8'hAA;
    localparam logic [15:0] TIMER_RESET_VAL = 16'hFFFC;
    localparam logic [7:0] STACK_RESET_VAL = 8'hFF;
    localparam logic [13:0] RESTART_VECTOR = 14'h3FFE;
    // watchdog control field positions
    localparam int CTRL_FLAG_BIT = 4;
    localparam int CTRL_CME_BIT = 3;
    localparam int CTRL_ENA_BIT = 2;
    // ------------------------------------------------------------
    // timing, in bus cycles (one bus cycle per aclk)
    // ------------------------------------------------------------
    localparam int POR_CYCLES = 4064;
    localparam int INT_RST_CYCLES = 4;
    localparam int WDG_BASE_BITS = 15;
    localparam int WDG_W = 22;
    localparam int CNT_W = 12;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MRW_POR = 3'b000,
        MRW_WAIT_PIN = 3'b001,
        MRW_RUN = 3'b010,
        MRW_INT_DRIVE = 3'b011,
        MRW_PIN_HELD = 3'b100
    } mrw_state_t;
endpackage

//--- mrw_reset_watchdog.sv
// reset sequencer and watchdog with an AXI4-Lite register slave
`timescale 1ns/1ns
// Operation
// R1 - drive reset pin low 4064 cycles after power-on
// R2 - internal reset drives pin low 4 cycles
// R3 - otherwise pin undriven, input only
// R4 - power-on holds reset 4064 cycles
// R5 - pin still low: stay in reset
// R6 - external pulse at least 1.5 cycles
// R7 - prescaler zero, timer counter FFFC
// R8 - clear compare level, enables, output bit
// R9 - all data direction registers cleared
// R10 - watchdog reset; flag cleared only on power-on
// R11 - wake-up timer register reset
// R12 - stack FF, interrupt mask, restart vector
// R13 - clear stop, wait, external interrupt latches
// R14 - serial unit disabled, its bits cleared
// R15 - tx empty and tx complete set
// R16 - serial baud rate bits cleared
// R17 - SPI disabled, slave, its bits cleared
// R18 - watchdog overflow resets like pin reset
// R19 - software writes 55 then AA
// R20 - other operations allowed between key writes
// R21 - key register read has no effect
// R22 - flag set on watchdog reset, read clears
// R23 - only armed AA restarts; others disarm
// R24 - sync pin; sequence starts after release
module mrw_reset_watchdog (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe,
    input wire logic clock_fail,
    output logic periph_reset,
    output logic reset_is_por,
    output logic [15:0] timer_load_value,
    output logic [13:0] restart_vector,
    output logic [7:0] stack_reset_value,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // pin synchroniser and sequencer
    // ------------------------------------------------------------
    logic pin_meta_q;
    logic pin_sync_q;
    mrw_pkg::mrw_state_t state_q;
    logic [mrw_pkg::CNT_W-1:0] cnt_q;
    logic wdg_fire;
    logic por_seen_q;

    // two-flop pin synchroniser; meta stage read only here
    always_ff @(posedge aclk) begin
        pin_meta_q <= rst_pin_i; // R24
        pin_sync_q <= pin_meta_q;
    end

    // por_n models the supply detector: low forces a fresh power-on
    // sequence; aresetn is the plain logic reset
    always_ff @(posedge aclk) begin
        if (!aresetn || !por_n) begin
            state_q <= mrw_pkg::MRW_POR;
            cnt_q <= '0;
        end else begin
            case (state_q)
                mrw_pkg::MRW_POR: begin
                    // count from the first running clock edge
                    if (cnt_q == mrw_pkg::CNT_W'(mrw_pkg::POR_CYCLES - 1)) begin
                        state_q <= mrw_pkg::MRW_WAIT_PIN; // R4
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                mrw_pkg::MRW_WAIT_PIN: begin
                    if (pin_sync_q) begin
                        state_q <= mrw_pkg::MRW_RUN; // R5 R24
                    end
                end
                mrw_pkg::MRW_RUN: begin
                    if (wdg_fire) begin
                        state_q <= mrw_pkg::MRW_INT_DRIVE; // R18 R2
                        cnt_q <= '0;
                    end else if (!pin_sync_q) begin
                        state_q <= mrw_pkg::MRW_PIN_HELD; // R6
                    end
                end
                mrw_pkg::MRW_INT_DRIVE: begin
                    if (cnt_q == mrw_pkg::CNT_W'(mrw_pkg::INT_RST_CYCLES - 1)) begin
                        state_q <= mrw_pkg::MRW_WAIT_PIN; // R2
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                mrw_pkg::MRW_PIN_HELD: begin
                    if (pin_sync_q) begin
                        state_q <= mrw_pkg::MRW_RUN; // R24
                    end
                end
                default: begin
                    state_q <= mrw_pkg::MRW_POR;
                end
            endcase
        end
    end

    // remembers that the current reset came from power-on
    always_ff @(posedge aclk) begin
        if (!aresetn || !por_n) begin
            por_seen_q <= 1'b1;
        end else if (state_q == mrw_pkg::MRW_RUN) begin
            por_seen_q <= 1'b0;
        end
    end

    // pin is open-drain style: only ever driven low
    always_comb begin
        rst_pin_o = 1'b0;
        rst_pin_oe = (state_q == mrw_pkg::MRW_POR) ||
            (state_q == mrw_pkg::MRW_INT_DRIVE); // R1 R2 R3
    end

    // reset broadcast to timer, ports, cpu, latches and serial units
    always_comb begin
        periph_reset = (state_q != mrw_pkg::MRW_RUN); // R7 R8 R9 R11 R13
        reset_is_por = por_seen_q; // R10
        timer_load_value = mrw_pkg::TIMER_RESET_VAL; // R7
        restart_vector = mrw_pkg::RESTART_VECTOR; // R12
        stack_reset_value = mrw_pkg::STACK_RESET_VAL; // R12
    end

    // ------------------------------------------------------------
    // serial unit control state held here
    // ------------------------------------------------------------
    // bits [7:0]: te re tie tx_complete_irq_enable rie idle_line_irq_enable rwu sbk
    // bits [11:8]: rx_data_full idle or nf/fe ; [13:12] tx_data_empty tc
    // bits [15:14] baud rate ; [20:16] spe spi_irq_enable spi_master_select spi_transfer_done spi_write_collision/spi_mode_fault
    logic [20:0] serial_q;
    localparam logic [20:0] SERIAL_RESET = 21'h003000;

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    logic [mrw_pkg::WDG_W-1:0] wdg_cnt_q;
    logic [4:0] ctrl_q;
    logic ctrl_written_q;
    logic cme_written_q;
    logic armed_q;
    logic flag_q;
    logic [mrw_pkg::WDG_W-1:0] wdg_limit;
    logic key_wr;
    logic ctrl_wr;
    logic ctrl_rd;
    logic [7:0] wr_byte;

    // timeout: 2^15 times 1, 4, 16 or 64
    always_comb begin
        wdg_limit = '0;
        wdg_limit[mrw_pkg::WDG_BASE_BITS + 2 * ctrl_q[1:0]] = 1'b1;
    end

    assign wdg_fire = ctrl_q[mrw_pkg::CTRL_ENA_BIT] &&
        ((wdg_cnt_q == wdg_limit - 1'b1) ||
        (ctrl_q[mrw_pkg::CTRL_CME_BIT] && clock_fail));

    // counter cleared by any reset or a valid key pair
    always_ff @(posedge aclk) begin
        if (!aresetn || periph_reset) begin
            wdg_cnt_q <= '0; // R10
        end else if (key_wr && armed_q && wr_byte == mrw_pkg::KEY_FIRE) begin
            wdg_cnt_q <= '0; // R19 R23
        end else if (ctrl_q[mrw_pkg::CTRL_ENA_BIT]) begin
            wdg_cnt_q <= wdg_cnt_q + 1'b1;
        end
    end

    // arm on 55, fire on AA; reads never touch it
    always_ff @(posedge aclk) begin
        if (!aresetn || periph_reset) begin
            armed_q <= 1'b0;
        end else if (key_wr) begin
            armed_q <= (wr_byte == mrw_pkg::KEY_ARM); // R20 R21 R23
        end
    end

    // control bits write-once after each reset
    always_ff @(posedge aclk) begin
        if (!aresetn || periph_reset) begin
            ctrl_q <= '0; // R10
            ctrl_written_q <= 1'b0;
            cme_written_q <= 1'b0;
        end else if (ctrl_wr) begin
            if (!ctrl_written_q) begin
                ctrl_q[2:0] <= wr_byte[2:0];
                ctrl_written_q <= 1'b1;
            end
            if (!cme_written_q) begin
                ctrl_q[mrw_pkg::CTRL_CME_BIT] <=
                    wr_byte[mrw_pkg::CTRL_CME_BIT];
                cme_written_q <= 1'b1;
            end
        end
    end

    // flag: set on self reset wins over read clear; pin keeps it
    always_ff @(posedge aclk) begin
        if (!aresetn || !por_n) begin
            flag_q <= 1'b0; // R10
        end else if (wdg_fire && state_q == mrw_pkg::MRW_RUN) begin
            flag_q <= 1'b1; // R22
        end else if (ctrl_rd) begin
            flag_q <= 1'b0; // R22
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_full_q;
    logic w_full_q;
    logic [9:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_go;
    logic aw_hit;

    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign wr_go = aw_full_q && w_full_q && !bvalid_q;
    assign wr_byte = w_data_q;
    assign aw_hit = (aw_addr_q == mrw_pkg::WDG_KEY_ADDR) ||
        (aw_addr_q == mrw_pkg::WDG_CTRL_ADDR) ||
        (aw_addr_q == mrw_pkg::SERIAL_ADDR);
    assign key_wr = wr_go && w_lane_q && aw_addr_q == mrw_pkg::WDG_KEY_ADDR;
    assign ctrl_wr = wr_go && w_lane_q && aw_addr_q == mrw_pkg::WDG_CTRL_ADDR;
    assign ctrl_rd = s_axi_arvalid && !rvalid_q &&
        s_axi_araddr[9:0] == mrw_pkg::WDG_CTRL_ADDR;

    // address and data captured in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_lane_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr[9:0];
            end else if (wr_go) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_full_q <= 1'b0;
            end
        end
    end

    // write response one cycle after both halves held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= mrw_pkg::AXI_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= aw_hit ? mrw_pkg::AXI_OKAY : mrw_pkg::AXI_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // serial unit bits: writable by software, forced on reset
    always_ff @(posedge aclk) begin
        if (!aresetn || periph_reset) begin
            serial_q <= SERIAL_RESET; // R14 R15 R16 R17
        end else if (wr_go && aw_addr_q == mrw_pkg::SERIAL_ADDR) begin
            serial_q <= {s_axi_wdata[20:8], w_data_q};
        end
    end

    // read data registered; key register reads as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= mrw_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= mrw_pkg::AXI_OKAY;
            rdata_q <= '0;
            if (s_axi_araddr[9:0] == mrw_pkg::WDG_CTRL_ADDR) begin
                rdata_q <= {27'h0000000, flag_q, ctrl_q[3:0]};
            end else if (s_axi_araddr[9:0] == mrw_pkg::WDG_KEY_ADDR) begin
                rdata_q <= '0; // R21
            end else if (s_axi_araddr[9:0] == mrw_pkg::RST_STATE_ADDR) begin
                rdata_q <= {28'h0000000, por_seen_q, state_q};
            end else if (s_axi_araddr[9:0] == mrw_pkg::SERIAL_ADDR) begin
                rdata_q <= {11'h000, serial_q};
            end else begin
                rresp_q <= mrw_pkg::AXI_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule

//--- mrw_reset_watchdog_checker.sv
// checker: timing properties on the reset and watchdog ports
`timescale 1ns/1ns
module mrw_reset_watchdog_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    input wire logic rst_pin_i,
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe,
    input wire logic periph_reset,
    input wire logic reset_is_por,
    input wire logic [15:0] timer_load_value,
    input wire logic [13:0] restart_vector,
    input wire logic [7:0] stack_reset_value,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    logic [12:0] oe_cnt_q;
    // ------------------------------------------------------------
    // helper: length of the current pin drive
    // ------------------------------------------------------------
    // cleared on release, so each drive is measured on its own
    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_pin_oe) oe_cnt_q <= 13'h0;
        else oe_cnt_q <= oe_cnt_q + 13'h1;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_pin_low_only: assert property (rst_pin_oe |-> !rst_pin_o)
        else $error("reset pin driven high");
    a_por_drive_len: assert property ($fell(rst_pin_oe) && reset_is_por
        |-> oe_cnt_q inside {[13'hFDF:13'hFE1]})
        else $error("power-on drive length wrong");
    a_int_drive_len: assert property ($fell(rst_pin_oe) && !reset_is_por
        |-> oe_cnt_q == 13'h4)
        else $error("internal drive length wrong");
    a_drive_in_reset: assert property (rst_pin_oe |-> periph_reset)
        else $error("pin driven outside reset");
    a_pin_low_holds: assert property (!rst_pin_i [*5] |-> periph_reset)
        else $error("low pin did not hold reset");
    a_por_restart: assert property (!por_n |=> rst_pin_oe && periph_reset)
        else $error("supply detect did not restart");
    a_reset_loads: assert property (timer_load_value == 16'hFFFC &&
        stack_reset_value == 8'hFF && restart_vector == 14'h3FFE)
        else $error("reset load values wrong");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
endmodule
bind mrw_reset_watchdog mrw_reset_watchdog_checker chk_i (.aclk, .aresetn,
    .por_n, .rst_pin_i, .rst_pin_o, .rst_pin_oe, .periph_reset, .reset_is_por,
    .timer_load_value, .restart_vector, .stack_reset_value, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready);

//--- mrw_reset_watchdog_tb.sv
// testbench: power-on, pin, watchdog and register sequences
`timescale 1ns/1ns
module mrw_reset_watchdog_tb;
    localparam logic [31:0] A_KEY = 32'(mrw_pkg::WDG_KEY_ADDR);
    localparam logic [31:0] A_CTRL = 32'(mrw_pkg::WDG_CTRL_ADDR);
    localparam logic [31:0] A_SER = 32'(mrw_pkg::SERIAL_ADDR);
    localparam logic [31:0] A_BAD = 32'h3FC;
    logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, hold_low = 1'b1;
    logic clock_fail = 1'b0, rst_pin_i, rst_pin_o, rst_pin_oe;
    logic periph_reset, reset_is_por, s_axi_awready, s_axi_wready;
    // answer readies stay high, so no strobe is re-raised in one step
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int err_total = 0, tests_run = 0, cyc = 0, t_svc, e;
    integer seed = 32'h994a;
    logic [7:0] k;
    always #2 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    mrw_pin_model pin_i (.aclk, .pin_o(rst_pin_o), .pin_oe(rst_pin_oe),
        .hold_low, .pin_level(rst_pin_i));
    mrw_reset_watchdog dut (.aclk, .aresetn, .por_n, .rst_pin_i, .rst_pin_o,
        .rst_pin_oe, .clock_fail, .periph_reset, .reset_is_por,
        .timer_load_value(), .restart_vector(), .stack_reset_value(),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    // ------------------------------------------------------------
    // expectations and reporting
    // ------------------------------------------------------------
    function automatic logic [31:0] exp_ctrl(input logic f, input logic [3:0] b);
        return {27'h0, f, b};
    endfunction
    function automatic int exp_tmo(input int cm);
        return 32768 << (2 * cm);
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x, string m);
        tests_run++;
        if (g !== x) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic hang;
        chk(32'h0, 32'h1, "wait ran out");
        test_done();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // w=1 waits for pin drive, w=0 for leaving reset
    task automatic wait_for(input logic w, input int b);
        int n;
        for (n = 0; n < b; n++) begin
            @(negedge aclk);
            if ((w ? rst_pin_oe : !periph_reset) === 1'b1) break;
        end
        @(posedge aclk);
        if (n == b) hang();
    endtask
    // ------------------------------------------------------------
    // bus master: handshakes judged on values sampled at the rising edge
    // ------------------------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                break;
            end
        end
        if (n == 64) hang();
    endtask
    task automatic rd(input logic [31:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
        end
        if (n == 64) hang();
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        tick(8);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        tick(4200);
        @(negedge aclk);
        chk(32'(periph_reset), 32'h1, "low pin let reset go");
        chk(32'(rst_pin_oe), 32'h0, "pin still driven");
        @(posedge aclk);
        hold_low <= 1'b0;
        wait_for(1'b0, 8);
        rd(A_SER);
        chk(d, {18'h0, 2'b11, 12'h0}, "serial reset state");
        rd(A_CTRL);
        chk(d, exp_ctrl(1'b0, 4'h0), "ctrl after power-on");
        rd(A_BAD);
        chk(32'(r), 32'(mrw_pkg::AXI_SLVERR), "unmapped read");
        wr(A_CTRL, 32'h4);
        wr(A_KEY, 32'(mrw_pkg::KEY_ARM));
        wr(A_KEY, 32'(mrw_pkg::KEY_FIRE));
        tick(20000);
        // unrelated traffic between the key writes must not disarm
        wr(A_KEY, 32'(mrw_pkg::KEY_ARM));
        rd(A_KEY);
        for (int i = 0; i < 3; i++) rd(A_CTRL + 32'({$random(seed)} % 4 * 12));
        wr(A_BAD, $random(seed));
        chk(32'(r), 32'(mrw_pkg::AXI_SLVERR), "unmapped write");
        wr(A_KEY, 32'(mrw_pkg::KEY_FIRE));
        t_svc = cyc;
        tick(10000);
        k = $random(seed);
        if (k == 8'hAA || k == 8'h55) k = 8'h3C;
        wr(A_KEY, 32'(mrw_pkg::KEY_ARM));
        wr(A_KEY, {24'h0, k});
        wr(A_KEY, 32'(mrw_pkg::KEY_FIRE));
        wait_for(1'b1, 40000);
        e = cyc - t_svc;
        chk(32'(e > exp_tmo(0) - 16 && e < exp_tmo(0) + 16), 32'h1, "period");
        @(negedge aclk);
        chk(32'(reset_is_por), 32'h0, "watchdog marked power-on");
        wait_for(1'b0, 64);
        hold_low <= 1'b1;
        tick(2);
        hold_low <= 1'b0;
        // let the synchroniser see the pulse before waiting for release
        tick(4);
        wait_for(1'b0, 16);
        rd(A_CTRL);
        chk(d, exp_ctrl(1'b1, 4'h0), "flag lost on pin reset");
        rd(A_CTRL);
        chk(d, exp_ctrl(1'b0, 4'h0), "flag not read-cleared");
        wr(A_CTRL, 32'hC);
        clock_fail <= 1'b1;
        wait_for(1'b1, 64);
        clock_fail <= 1'b0;
        wait_for(1'b0, 64);
        por_n <= 1'b0;
        tick(1);
        por_n <= 1'b1;
        wait_for(1'b0, 4200);
        rd(A_CTRL);
        chk(d, exp_ctrl(1'b0, 4'h0), "flag kept over power-on");
        test_done();
    end
endmodule
